/* File: logic/bdi_pkg.sv */
// Shared constants and types for the bundle dispersal issue block.
// Assumes a single core clock and three instruction slots per bundle.
package bdi_pkg;

  // Decoupling buffer geometry
  localparam int BUF_DEPTH = 8;
  localparam int PTR_W = 3;
  localparam int CNT_W = 4;
  localparam int SLOTS = 3;
  localparam int WIN = 6;
  localparam int PICK_W = 3;
  // Issue ports and execution units
  localparam int NPORT = 9;
  localparam int NUNIT = 17;
  localparam int UNIT_W = 5;
  // Register and predicate files
  localparam int NREG = 128;
  localparam int REG_W = 7;
  localparam int NPRED = 64;
  localparam int QP_W = 6;
  localparam int WB_LANES = 4;

  // Level at or below which fetch may push a full 32-byte pair
  localparam logic [CNT_W-1:0] PUSH_ROOM = 4'h6;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] CNT_TWO = 4'h2;
  localparam logic [CNT_W-1:0] CNT_FULL = 4'h8;
  localparam logic [REG_W-1:0] REG_ZERO = 7'h00;
  localparam logic [QP_W-1:0] QP_TRUE = 6'h00;
  localparam logic [NPRED-1:0] PRED_RST = 64'h0000_0000_0000_0001;

  // Issue port type
  typedef enum logic [1:0] {
    UT_MEM = 2'h0,
    UT_INT = 2'h1,
    UT_FP  = 2'h2,
    UT_BR  = 2'h3
  } bdi_unit_t;

  // One decoded instruction slot (sub picks a unit behind the port)
  typedef struct packed {
    logic [1:0] sub;
    bdi_unit_t unit;
    logic [QP_W-1:0] qp;
    logic [REG_W-1:0] src1;
    logic [REG_W-1:0] src2;
    logic [REG_W-1:0] dst;
    logic dstEn;
  } bdi_instr_t;

  // Slot 0 is leftmost in program order
  typedef struct packed {
    bdi_instr_t [SLOTS-1:0] slot;
  } bdi_bundle_t;

  typedef struct packed {
    logic valid;
    logic takesEffect;
    bdi_instr_t instr;
  } bdi_issue_t;

  typedef struct packed {
    logic valid;
    logic [REG_W-1:0] num;
  } bdi_wb_t;

  typedef struct packed {
    logic en;
    logic [QP_W-1:0] idx;
    logic val;
  } bdi_predwr_t;

  // Ports in order: mem_issue_a/b, int_issue_a/b, fp_issue_a/b, branch_issue_a/b/c
  localparam bdi_unit_t PORT_TYPE [NPORT] =
    '{UT_MEM, UT_MEM, UT_INT, UT_INT, UT_FP, UT_FP, UT_BR, UT_BR, UT_BR};
  // First unit behind each port, and mask of the sub field used to pick among its units
  localparam logic [UNIT_W-1:0] UNIT_BASE [NPORT] =
    '{5'h00, 5'h01, 5'h02, 5'h06, 5'h0a, 5'h0c, 5'h0e, 5'h0f, 5'h10};
  localparam logic [1:0] SUB_MASK [NPORT] =
    '{2'h0, 2'h0, 2'h3, 2'h3, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0};

endpackage

/* File: logic/bdi_port_alloc.sv */
// Combinational port allocator for up to six candidate instructions.
// Assumes candidates arrive in program order and busy comes from a scoreboard.
`timescale 1ns/100ps
module bdi_port_alloc
  import bdi_pkg::*;
(
  input wire bdi_instr_t [WIN-1:0] cand, // Candidates, index 0 oldest
  input wire logic [WIN-1:0] candValid,
  input wire logic [NREG-1:0] busy, // Results still in flight
  output logic [NPORT-1:0] portValid,
  output logic [NPORT-1:0][PICK_W-1:0] portPick, // Candidate index per port
  output logic [PICK_W-1:0] issueCnt
);

  logic stop; // Dispersal halted at an older instruction
  logic hit; // A free port of the right type exists
  logic dep; // Depends on in-flight or same-group result
  logic [NPORT-1:0] used;
  logic [NREG-1:0] groupDst; // Destinations taken earlier this cycle
  logic [3:0] sel;

  // Walk candidates left to right; the first that fails stops all younger ones
  always_comb begin
    stop = 1'b0;
    used = '0;
    groupDst = '0;
    portValid = '0;
    portPick = '0;
    issueCnt = '0;
    hit = 1'b0;
    dep = 1'b0;
    sel = '0;
    for (int i = 0; i < WIN; i++) begin
      hit = 1'b0;
      sel = '0;
      // First free port of the matching type
      for (int p = 0; p < NPORT; p++) begin
        if (!hit && !used[p] && PORT_TYPE[p] == cand[i].unit) begin
          hit = 1'b1;
          sel = 4'(p);
        end
      end
      // Register zero is never marked, so it never blocks
      dep = busy[cand[i].src1] | busy[cand[i].src2] |
            (cand[i].dstEn & busy[cand[i].dst]) |
            groupDst[cand[i].src1] | groupDst[cand[i].src2];
      if (candValid[i] && !stop && hit && !dep) begin
        used[sel] = 1'b1;
        portValid[sel] = 1'b1;
        portPick[sel] = PICK_W'(i);
        issueCnt = issueCnt + 3'h1;
        if (cand[i].dstEn && cand[i].dst != REG_ZERO) begin
          groupDst[cand[i].dst] = 1'b1;
        end
      end else begin
        // Oversubscribed, dependent or absent: strict order forbids skipping
        stop = 1'b1;
      end
    end
  end

endmodule

/* File: logic/bdi_dispersal_issue.sv */
// Front-end issue: eight-bundle decoupling buffer, dispersal onto nine issue
// ports, register scoreboard and predicate file.
// Assumes fetch and execution units sit on the same clock; no pin crossing.
//
// Functional notes
// - Decoupling buffer holds eight bundles.
// - Nine issue ports: 2 mem, 2 int, 2 fp, 3 branch.
// - Ports feed seventeen execution units by group.
// - Present two bundles; refill as consumed.
// - Issue up to six, strictly in order.
// - First free port; stop at dependency/oversubscription.
// - Scoreboard holds dependents until results return.
// - Sixty-four predicates qualify each instruction.
`timescale 1ns/100ps
module bdi_dispersal_issue
  import bdi_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic fetchValid, // Fetch offers bundles this cycle
  input wire logic fetchTwo, // Offer holds two bundles, else one
  input wire bdi_bundle_t [1:0] fetchData, // Index 0 is the older bundle
  output logic fetchReady, // Offer is taken when valid and ready
  input wire bdi_wb_t [WB_LANES-1:0] wb, // Result returns clearing the scoreboard
  input wire bdi_predwr_t predWr, // Predicate register write
  output bdi_issue_t [NPORT-1:0] issuePort, // Nine issue ports, registered
  output logic [NUNIT-1:0] unitGo, // One-cycle start per execution unit
  output logic [CNT_W-1:0] bufLevel // Bundles held in the buffer
);

  // Buffer state
  bdi_bundle_t buf_r [BUF_DEPTH];
  bdi_bundle_t buf_nxt [BUF_DEPTH];
  logic [PTR_W-1:0] head_r, head_nxt;
  logic [PTR_W-1:0] tail_r, tail_nxt;
  logic [CNT_W-1:0] count_r, count_nxt;
  logic [1:0] slotOff_r, slotOff_nxt; // Slots already issued from head bundle
  // Scoreboard and predicates
  logic [NREG-1:0] busy_r, busy_nxt;
  logic [NPRED-1:0] pred_r, pred_nxt;
  // Output registers
  bdi_issue_t [NPORT-1:0] issue_r, issue_nxt;
  logic [NUNIT-1:0] unitGo_r, unitGo_nxt;

  // Dispersal window
  bdi_instr_t [WIN-1:0] cand;
  logic [WIN-1:0] candValid;
  logic [NPORT-1:0] portValid;
  logic [NPORT-1:0][PICK_W-1:0] portPick;
  logic [PICK_W-1:0] issueCnt;
  logic [3:0] pos; // Slot position across the two presented bundles
  logic [3:0] newPos;
  logic [CNT_W-1:0] pushN, popN;
  logic [UNIT_W-1:0] unitIdx;

  // Room for a whole 32-byte pair is required, so a two-bundle offer never splits
  assign fetchReady = (count_r <= PUSH_ROOM);
  assign issuePort = issue_r;
  assign unitGo = unitGo_r;
  assign bufLevel = count_r;

  // Present the two oldest bundles, skipping slots already issued
  always_comb begin
    pos = '0;
    for (int i = 0; i < WIN; i++) begin
      pos = {2'h0, slotOff_r} + 4'(i);
      // Only two bundles are ever visible, however full the buffer is
      candValid[i] = (pos < 4'(WIN)) && (CNT_W'(pos / 4'(SLOTS)) < count_r);
      cand[i] = buf_r[head_r + PTR_W'(pos / 4'(SLOTS))].slot[pos % 4'(SLOTS)];
    end
  end

  // Allocator picks ports for the oldest run of issuable instructions
  bdi_port_alloc u_alloc (
    .cand(cand),
    .candValid(candValid),
    .busy(busy_r),
    .portValid(portValid),
    .portPick(portPick),
    .issueCnt(issueCnt)
  );

  // Buffer pointers, level and slot offset
  always_comb begin
    buf_nxt = buf_r;
    pushN = '0;
    if (fetchValid && fetchReady) begin
      buf_nxt[tail_r] = fetchData[0];
      pushN = CNT_ONE;
      if (fetchTwo) begin
        buf_nxt[tail_r + PTR_W'(1)] = fetchData[1];
        pushN = CNT_TWO;
      end
    end
    // A bundle is released as soon as all three of its slots have gone
    newPos = {2'h0, slotOff_r} + {1'b0, issueCnt};
    if (newPos >= 4'(WIN)) begin
      popN = CNT_TWO;
    end else if (newPos >= 4'(SLOTS)) begin
      popN = CNT_ONE;
    end else begin
      popN = '0;
    end
    slotOff_nxt = 2'(newPos - 4'(SLOTS) * popN);
    head_nxt = head_r + PTR_W'(popN);
    tail_nxt = tail_r + PTR_W'(pushN);
    count_nxt = count_r + pushN - popN;
  end

  // Buffer contents carry no reset; the level says which entries mean anything
  always_ff @(posedge clk) begin
    buf_r <= buf_nxt;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      head_r <= '0;
      tail_r <= '0;
      count_r <= '0;
      slotOff_r <= '0;
    end else begin
      head_r <= head_nxt;
      tail_r <= tail_nxt;
      count_r <= count_nxt;
      slotOff_r <= slotOff_nxt;
    end
  end

  // Scoreboard: returns clear, new issues mark; marking wins on a clash
  always_comb begin
    busy_nxt = busy_r;
    for (int l = 0; l < WB_LANES; l++) begin
      if (wb[l].valid) begin
        busy_nxt[wb[l].num] = 1'b0;
      end
    end
    for (int p = 0; p < NPORT; p++) begin
      if (portValid[p] && cand[portPick[p]].dstEn && cand[portPick[p]].dst != REG_ZERO) begin
        busy_nxt[cand[portPick[p]].dst] = 1'b1;
      end
    end
  end

  // Predicate file; entry zero always reads true
  always_comb begin
    pred_nxt = pred_r;
    if (predWr.en && predWr.idx != QP_TRUE) begin
      pred_nxt[predWr.idx] = predWr.val;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_r <= '0;
      pred_r <= PRED_RST;
    end else begin
      busy_r <= busy_nxt;
      pred_r <= pred_nxt;
    end
  end

  // Issue ports, one generate lane per port
  generate
    for (genvar p = 0; p < NPORT; p++) begin : g_port
      always_comb begin
        issue_nxt[p].valid = portValid[p];
        issue_nxt[p].instr = cand[portPick[p]];
        // Predicate read at issue; a write in the same cycle is seen next cycle
        issue_nxt[p].takesEffect = pred_r[cand[portPick[p]].qp];
      end
    end
  endgenerate

  // Each port feeds the unit picked by its base plus masked sub field
  always_comb begin
    unitGo_nxt = '0;
    unitIdx = '0;
    for (int p = 0; p < NPORT; p++) begin
      unitIdx = UNIT_BASE[p] + {3'h0, cand[portPick[p]].sub & SUB_MASK[p]};
      if (portValid[p]) begin
        unitGo_nxt[unitIdx] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      issue_r <= '0;
      unitGo_r <= '0;
    end else begin
      issue_r <= issue_nxt;
      unitGo_r <= unitGo_nxt;
    end
  end

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic [NPORT-1:0] outValid;
  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      outValid[p] = issue_r[p].valid;
    end
  end

  property p_bufBound;
    count_r <= CNT_FULL;
  endproperty
  a_bufBound: assert property (p_bufBound) else $error("buffer level above eight");

  property p_backpressure;
    (count_r > PUSH_ROOM) |-> !fetchReady;
  endproperty
  a_backpressure: assert property (p_backpressure) else $error("ready while near full");

  property p_emptyIdle;
    (count_r == '0) |=> (outValid == '0);
  endproperty
  a_emptyIdle: assert property (p_emptyIdle) else $error("issue from empty buffer");

  property p_maxSix;
    $countones(outValid) <= WIN;
  endproperty
  a_maxSix: assert property (p_maxSix) else $error("more than six issued");

  property p_unitCount;
    $countones(unitGo_r) == $countones(outValid);
  endproperty
  a_unitCount: assert property (p_unitCount) else $error("unit starts mismatch ports");

  property p_levelStep;
    count_r == $past(count_r) + $past(pushN) - $past(popN);
  endproperty
  a_levelStep: assert property (p_levelStep) else $error("buffer level step wrong");

  sequence s_predWrite;
    predWr.en && (predWr.idx != QP_TRUE);
  endsequence
  property p_predApplied;
    s_predWrite |=> (pred_r[$past(predWr.idx)] == $past(predWr.val)) && pred_r[0];
  endproperty
  a_predApplied: assert property (p_predApplied) else $error("predicate not written");

  generate
    for (genvar p = 0; p < NPORT; p++) begin : g_chk
      property p_portType;
        issue_r[p].valid |-> (issue_r[p].instr.unit == PORT_TYPE[p]);
      endproperty
      a_portType: assert property (p_portType) else $error("wrong port type");

      property p_marksBusy;
        (issue_r[p].valid && issue_r[p].instr.dstEn && issue_r[p].instr.dst != REG_ZERO)
          |-> busy_r[issue_r[p].instr.dst];
      endproperty
      a_marksBusy: assert property (p_marksBusy) else $error("issued dest not marked");

      if (p > 0) begin : g_first
        if (PORT_TYPE[p] == PORT_TYPE[p-1]) begin : g_same
          property p_firstFree;
            issue_r[p].valid |-> issue_r[p-1].valid;
          endproperty
          a_firstFree: assert property (p_firstFree) else $error("later port before first");
        end
      end
    end
  endgenerate

endmodule

/* File: verif/bdi_fetch_model.sv */
// Fetch-side partner: offers queued bundles, two per clock while the block has room.
// Assumes the bench loads bundles with push() and fetchReady is combinational.
`timescale 1ns/100ps
module bdi_fetch_model
  import bdi_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic fetchReady,
  output logic fetchValid,
  output logic fetchTwo,
  output bdi_bundle_t [1:0] fetchData
);
  bdi_bundle_t q[$]; // Bundles not yet taken
  int n; // Bundles left after this edge

  // Bench hook to queue one bundle
  task automatic push(input bdi_bundle_t b);
    q.push_back(b);
  endtask

  // Retire what was taken, then offer the next pair
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      fetchValid <= 1'b0;
      fetchTwo <= 1'b0;
      fetchData <= '0;
    end else if (!fetchValid || fetchReady) begin
      // A refused offer stands unchanged, pair size included, until it is taken
      if (fetchValid) begin
        void'(q.pop_front());
        if (fetchTwo) begin
          void'(q.pop_front());
        end
      end
      n = q.size();
      fetchValid <= (n > 0);
      fetchTwo <= (n > 1);
      // Unused lanes carry inverted data so a stale copy never looks valid
      fetchData <= (n > 1) ? {q[1], q[0]} : (n == 1) ? {~q[0], q[0]} : ~fetchData;
    end
  end
endmodule

/* File: verif/testbench.sv */
// Self-checking bench for the dispersal issue block.
// Assumes the fetch model as partner; results and predicates are driven here.
`timescale 1ns/100ps
module testbench;
  import bdi_pkg::*;
  logic clk;
  logic rst;
  logic fetchValid;
  logic fetchTwo;
  logic fetchReady;
  bdi_bundle_t [1:0] fetchData;
  bdi_wb_t [WB_LANES-1:0] wb; // Result returns
  bdi_predwr_t predWr;
  bdi_issue_t [NPORT-1:0] issuePort;
  logic [NUNIT-1:0] unitGo;
  logic [CNT_W-1:0] bufLevel;
  int err_total = 0;
  int tests_run = 0;

  bdi_fetch_model fm (.clk(clk), .rst(rst), .fetchReady(fetchReady),
    .fetchValid(fetchValid), .fetchTwo(fetchTwo), .fetchData(fetchData));
  bdi_dispersal_issue dut (.clk(clk), .rst(rst), .fetchValid(fetchValid),
    .fetchTwo(fetchTwo), .fetchData(fetchData), .fetchReady(fetchReady), .wb(wb),
    .predWr(predWr), .issuePort(issuePort), .unitGo(unitGo), .bufLevel(bufLevel));

  // 40 MHz core clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Build one slot; a nonzero destination marks a result
  function automatic bdi_instr_t mk(bdi_unit_t u, logic [1:0] s, logic [5:0] qp,
                                    logic [6:0] a, logic [6:0] d);
    mk = '{sub:s, unit:u, qp:qp, src1:a, src2:7'h00, dst:d, dstEn:(d != 7'h00)};
  endfunction
  // Slot 0 is leftmost
  function automatic bdi_bundle_t bd(bdi_instr_t i0, bdi_instr_t i1, bdi_instr_t i2);
    bd = {i2, i1, i0};
  endfunction
  // Valid bits of the nine ports
  function automatic logic [8:0] vm();
    for (int p = 0; p < NPORT; p++) begin
      vm[p] = issuePort[p].valid;
    end
  endfunction

  task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Bounded wait at negedges for the first issuing cycle; always steps one edge first
  // so the ports still showing the previous test's issue are never mistaken for it
  task automatic wait_issue();
    @(negedge clk);
    for (int i = 0; i < 20 && vm() == 9'h000; i++) begin
      @(negedge clk);
    end
    chk("issue seen", vm() != 9'h000, 1);
  endtask

  task automatic t_reset();
    @(negedge clk);
    chk("level", bufLevel, 0);
    chk("ready", fetchReady, 1);
    chk("valids", vm(), 0);
    chk("go", unitGo, 0);
    $display("test reset done");
  endtask

  // Sub field selects the unit behind each integer port
  task automatic t_walk();
    fm.push(bd(mk(UT_MEM, 0, 0, 0, 0), mk(UT_INT, 3, 0, 0, 0), mk(UT_INT, 1, 0, 0, 0)));
    wait_issue();
    chk("walk valids", vm(), 9'h00d);
    chk("walk go", unitGo, 17'h000a1);
    $display("test walk done");
  endtask

  // Third memory op waits a cycle, then shares it with a branch bundle
  task automatic t_over();
    fm.push(bd(mk(UT_MEM, 0, 0, 0, 0), mk(UT_MEM, 0, 0, 0, 0), mk(UT_MEM, 0, 0, 0, 0)));
    fm.push(bd(mk(UT_BR, 0, 0, 0, 0), mk(UT_BR, 0, 0, 0, 0), mk(UT_BR, 0, 0, 0, 0)));
    wait_issue();
    chk("over c1", vm(), 9'h003);
    @(negedge clk);
    chk("over c2", vm(), 9'h1c1);
    chk("over go", unitGo, 17'h1c001);
    $display("test oversubscribe done");
  endtask

  // Reader of r5 holds until the result returns
  task automatic t_dep();
    fm.push(bd(mk(UT_INT, 0, 0, 0, 7'h05), mk(UT_INT, 0, 0, 7'h05, 0),
               mk(UT_MEM, 0, 0, 0, 0)));
    wait_issue();
    chk("dep c1", vm(), 9'h004);
    repeat (3) begin
      @(negedge clk);
      chk("dep held", vm(), 0);
    end
    @(posedge clk) wb[0] <= '{valid:1'b1, num:7'h05};
    @(posedge clk) wb[0] <= '0;
    wait_issue();
    chk("dep go", vm(), 9'h005);
    chk("dep src", issuePort[2].instr.src1, 7'h05);
    $display("test dependency done");
  endtask

  // p3 set, p4 left clear, p0 write ignored
  task automatic t_pred();
    @(posedge clk) predWr <= '{en:1'b1, idx:6'h03, val:1'b1};
    @(posedge clk) predWr <= '{en:1'b1, idx:6'h00, val:1'b0};
    @(posedge clk) predWr <= '0;
    fm.push(bd(mk(UT_INT, 0, 6'h03, 0, 0), mk(UT_INT, 0, 6'h04, 0, 0),
               mk(UT_MEM, 0, 6'h00, 0, 0)));
    wait_issue();
    chk("pred on", issuePort[2].takesEffect, 1);
    chk("pred off", issuePort[3].takesEffect, 0);
    chk("pred zero", issuePort[0].takesEffect, 1);
    $display("test predicate done");
  endtask

  // Block the head, fill to full, then release and drain six wide
  task automatic t_fill();
    int tot;
    bit six;
    tot = 0;
    six = 0;
    fm.push(bd(mk(UT_INT, 0, 0, 0, 7'h09), mk(UT_MEM, 0, 0, 0, 0), mk(UT_MEM, 0, 0, 0, 0)));
    wait_issue();
    repeat (10) fm.push(bd(mk(UT_MEM, 0, 0, 7'h09, 0), mk(UT_INT, 0, 0, 0, 0),
                           mk(UT_FP, 0, 0, 0, 0)));
    for (int i = 0; i < 20 && fetchReady === 1'b1; i++) begin
      @(negedge clk);
    end
    repeat (3) @(negedge clk);
    chk("full level", bufLevel, 4'h8);
    chk("full ready", fetchReady, 0);
    chk("blocked", vm(), 0);
    @(posedge clk) wb[2] <= '{valid:1'b1, num:7'h09};
    @(posedge clk) wb[2] <= '0;
    for (int i = 0; i < 40 && tot < 30; i++) begin
      @(negedge clk);
      tot += $countones(vm());
      if (vm() == 9'h03f) six = 1;
    end
    chk("drained", tot, 30);
    chk("six wide", six, 1);
    @(negedge clk);
    @(negedge clk);
    chk("empty level", bufLevel, 0);
    chk("empty idle", vm(), 0);
    $display("test fill drain done");
  endtask

  // Mid-run reset must clear the scoreboard and the predicates (p3 was set earlier)
  task automatic t_rerst();
    fm.push(bd(mk(UT_INT, 0, 0, 0, 7'h0b), mk(UT_MEM, 0, 0, 0, 0), mk(UT_MEM, 0, 0, 0, 0)));
    wait_issue();
    chk("pre valids", vm(), 9'h007);
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("rerst level", bufLevel, 0);
    chk("rerst ready", fetchReady, 1);
    chk("rerst valids", vm(), 0);
    chk("rerst go", unitGo, 0);
    fm.push(bd(mk(UT_INT, 0, 6'h03, 7'h0b, 0), mk(UT_MEM, 0, 0, 0, 0),
               mk(UT_MEM, 0, 0, 0, 0)));
    wait_issue();
    chk("rerst busy", vm(), 9'h007);
    chk("rerst pred", issuePort[2].takesEffect, 0);
    $display("test mid reset done");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Watchdog: tests need well under a thousand cycles
  initial begin
    #75000;
    err_total++;
    results();
  end

  initial begin
    rst = 1'b1;
    wb = '0;
    predWr = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_walk();
    t_over();
    t_dep();
    t_pred();
    t_fill();
    t_rerst();
    results();
  end
endmodule
